/* design/flash_status_poller.sv */
// host poller of flash program/erase status bits
//
// How it works
// [R1] device inverts bit 7 while programming
// [R2] poll bit 7 at programmed address
// [R3] protected program: polling about 1 us
// [R4] erase shows 0, done/suspend shows 1
// [R5] erase poll address inside erased sector
// [R6] all-protected erase: polling about 400 us
// [R7] protected sector bit 7 unreliable
// [R8] take array data from later read
// [R9] bit 7 may flip before other lines
// [R10] recheck bit 7 after timeout flag
// [R11] ready/busy low while device busy
// [R12] status valid after last write edge
// [R13] bit 6 toggles every read while busy
// [R14] bit 6 valid from last write edge
// [R15] all-protected erase toggles about 400 us
// [R16] protected program toggles about 1 us
// [R17] bit 6 stops during erase suspend
// [R18] suspend-program bit 6 toggles until done
// [R19] bit 2 toggles in erased sectors
// [R20] bit 2 valid from last write edge
// [R21] recheck toggle after timeout flag
// [R22] compare two consecutive toggle reads
// [R23] bit 5 high means operation failed
// [R24] after failure issue reset command
// [R25] toggle bits flip once per read
`timescale 1ns/1ps
module flash_status_poller
    import flash_status_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  sys_rst_in,
    input  wire logic [3:0]            reg_addr_in,
    input  wire logic [31:0]           reg_wdata_in,
    input  wire logic                  reg_wr_in,
    input  wire logic                  reg_rd_in,
    output logic      [31:0]           reg_rdata_out,
    output logic      [ADDR_W-1:0]     flash_addr_out,
    input  wire logic [DATA_W-1:0]     flash_dq_in,
    output logic      [DATA_W-1:0]     flash_dq_out,
    output logic                       flash_dq_oe_out,
    output logic                       flash_ce_n_out,
    output logic                       flash_oe_n_out,
    output logic                       flash_we_n_out,
    input  wire logic                  ready_busy_n_in,
    output logic                       busy_out
);
    import flash_status_pkg::*;

    flash_bus_if bus ();

    logic [DATA_W-1:0] dq_sync;
    logic              rdy_sync;
    logic [ADDR_W-1:0] poll_addr;
    logic [DATA_W-1:0] exp_data;
    logic              erase_mode;
    logic              toggle_mode;
    logic              done;
    logic              fail;
    logic              susp;
    logic [DATA_W-1:0] prev_rd;
    logic              have_prev;
    logic              tmo_seen;
    logic [DATA_W-1:0] result;
    poll_state_t       state;
    logic              start;

    flash_sync #(.W(DATA_W + 1)) u_sync (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({ready_busy_n_in, flash_dq_in}),
        .sync_out   ({rdy_sync, dq_sync})
    );

    flash_cycle_engine u_engine (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .bus        (bus),
        .dq_sync_in (dq_sync),
        .addr_out   (flash_addr_out),
        .dq_o_out   (flash_dq_out),
        .dq_oe_out  (flash_dq_oe_out),
        .ce_n_out   (flash_ce_n_out),
        .oe_n_out   (flash_oe_n_out),
        .we_n_out   (flash_we_n_out)
    );

    assign start = reg_wr_in && reg_addr_in == REG_CTRL
                   && reg_wdata_in[CTRL_START] && state == ST_IDLE;

    // software settings
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            poll_addr   <= '0;
            exp_data    <= '0;
            erase_mode  <= 1'b0;
            toggle_mode <= 1'b0;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                REG_ADDR: poll_addr <= reg_wdata_in[ADDR_W-1:0];
                REG_DATA: exp_data  <= reg_wdata_in[DATA_W-1:0];
                REG_CTRL: if (state == ST_IDLE) begin
                    erase_mode  <= reg_wdata_in[CTRL_ERASE];
                    toggle_mode <= reg_wdata_in[CTRL_TOGGLE];
                end
                default: ;
            endcase
        end
    end

    function automatic logic status_done(input logic [DATA_W-1:0] rd,
                                         input logic [DATA_W-1:0] pr);
        logic d;
        d = 1'b0;
        if (toggle_mode)
            // [R13] [R14] [R15] [R16] [R18] toggling stops when done
            // [R22] two-read toggle compare
            d = rd[BIT_TOG1] == pr[BIT_TOG1];
        else if (erase_mode)
            // [R4] erase ends at one
            d = rd[BIT_POLL];
        else
            // [R3] [R6] [R7] poll ends on return to read mode
            // [R1] true data means done
            d = rd[BIT_POLL] == exp_data[BIT_POLL];
        return d;
    endfunction

    // polling sequence
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state     <= ST_IDLE;
            bus.req   <= 1'b0;
            bus.wr    <= 1'b0;
            bus.addr  <= '0;
            bus.wdata <= '0;
            done      <= 1'b0;
            fail      <= 1'b0;
            susp      <= 1'b0;
            have_prev <= 1'b0;
            tmo_seen  <= 1'b0;
            prev_rd   <= '0;
            result    <= '0;
        end else begin
            bus.req <= 1'b0;
            unique case (state)
                ST_IDLE: if (start) begin
                    // [R12] poll begins after the command's last write
                    done      <= 1'b0;
                    fail      <= 1'b0;
                    susp      <= 1'b0;
                    have_prev <= 1'b0;
                    tmo_seen  <= 1'b0;
                    state     <= ST_READ;
                    bus.req   <= 1'b1;
                    bus.wr    <= 1'b0;
                    // [R2] [R5] read at the target address
                    bus.addr  <= poll_addr;
                end
                ST_READ: if (bus.done) begin
                    prev_rd   <= bus.rdata;
                    have_prev <= 1'b1;
                    if (have_prev && status_done(bus.rdata, prev_rd)) begin
                        // [R8] [R9] fetch data on a fresh read
                        state   <= ST_FINAL;
                        bus.req <= 1'b1;
                    end else if (!have_prev && !toggle_mode
                                 && status_done(bus.rdata, prev_rd)) begin
                        state   <= ST_FINAL;
                        bus.req <= 1'b1;
                    end else if (bus.rdata[BIT_TMO] && !tmo_seen) begin
                        // [R10] [R21] one more read after timeout flag
                        tmo_seen <= 1'b1;
                        state    <= ST_RECHECK;
                        bus.req  <= 1'b1;
                    end else begin
                        bus.req <= 1'b1;
                    end
                end
                ST_RECHECK: if (bus.done) begin
                    prev_rd <= bus.rdata;
                    if (status_done(bus.rdata, prev_rd)) begin
                        state   <= ST_FINAL;
                        bus.req <= 1'b1;
                    end else begin
                        // [R23] [R24] failure needs reset command
                        fail      <= 1'b1;
                        state     <= ST_RESET;
                        bus.req   <= 1'b1;
                        bus.wr    <= 1'b1;
                        bus.wdata <= RESET_CMD;
                    end
                end
                ST_RESET: if (bus.done) begin
                    bus.wr <= 1'b0;
                    done   <= 1'b1;
                    state  <= ST_IDLE;
                end
                ST_FINAL: if (bus.done) begin
                    // [R17] [R19] [R20] bit 6 still, bit 2 moving
                    susp   <= erase_mode && toggle_mode
                              && bus.rdata[BIT_TOG1] == prev_rd[BIT_TOG1]
                              && bus.rdata[BIT_TOG2] != prev_rd[BIT_TOG2];
                    result <= bus.rdata;
                    done   <= 1'b1;
                    state  <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // register reads and busy pin
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= '0;
            busy_out      <= 1'b0;
        end else begin
            // [R11] pin low means device busy
            busy_out <= !rdy_sync;
            reg_rdata_out <= '0;
            if (reg_rd_in) begin
                unique case (reg_addr_in)
                    REG_CTRL:   reg_rdata_out <= {29'h0, toggle_mode,
                                                  erase_mode, 1'b0};
                    REG_ADDR:   reg_rdata_out <= {9'h0, poll_addr};
                    REG_DATA:   reg_rdata_out <= {16'h0, exp_data};
                    REG_STATUS: reg_rdata_out <= {27'h0, susp, rdy_sync,
                                                  fail, done,
                                                  state != ST_IDLE};
                    REG_RESULT: reg_rdata_out <= {16'h0, result};
                    default:    reg_rdata_out <= '0;
                endcase
            end
        end
    end

    // [R25] toggle compare only after full read
    toggle_pair_a: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (state == ST_READ && bus.done) |=> have_prev)
        else $error("read not recorded");

    // [R24] reset command after failure
    fail_reset_a: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        $rose(fail) |-> state == ST_RESET && bus.wdata == RESET_CMD)
        else $error("no reset after fail");

    // [R8] data taken from a later read
    later_read_a: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        (state == ST_FINAL && bus.done) |=> done && state == ST_IDLE)
        else $error("final read lost");

    // [R11] busy follows pin
    busy_pin_a: assert property (@(posedge sys_clk_in)
        disable iff (sys_rst_in)
        !rdy_sync |=> busy_out)
        else $error("busy not shown");

    // [R12] no flash cycle while idle
    idle_quiet_a: assert property (@(posedge sys_clk_in) // [R12]
        disable iff (sys_rst_in)
        (state == ST_IDLE) |-> !bus.req)
        else $error("request while idle");

    // [R24] writes only for the reset command
    reset_write_a: assert property (@(posedge sys_clk_in) // [R24]
        disable iff (sys_rst_in)
        (bus.req && bus.wr) |-> state == ST_RESET)
        else $error("stray flash write");
endmodule

/* design/flash_status_pkg.sv */
// constants and types for the flash status poller
package flash_status_pkg;
    localparam int          ADDR_W          = 23;
    localparam int          DATA_W          = 16;
    // register offsets of the command port
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_ADDR        = 4'h1;
    localparam logic [3:0]  REG_DATA        = 4'h2;
    localparam logic [3:0]  REG_STATUS      = 4'h3;
    localparam logic [3:0]  REG_RESULT      = 4'h4;
    // control register fields
    localparam int          CTRL_START      = 0;
    localparam int          CTRL_ERASE      = 1;
    localparam int          CTRL_TOGGLE     = 2;
    // status register fields
    localparam int          STAT_BUSY       = 0;
    localparam int          STAT_DONE       = 1;
    localparam int          STAT_FAIL       = 2;
    localparam int          STAT_RDY        = 3;
    localparam int          STAT_SUSP       = 4;
    // status bit positions on the flash data bus
    localparam int          BIT_POLL        = 7;
    localparam int          BIT_TOG1        = 6;
    localparam int          BIT_TMO         = 5;
    localparam int          BIT_TOG2        = 2;
    // read cycle timing
    localparam int          CLK_MHZ         = 25;
    localparam int          T_ACC_NS        = 110;
    localparam int          ACC_CYC         = (T_ACC_NS * CLK_MHZ + 999) / 1000;
    localparam int          T_GAP_NS        = 40;
    localparam int          GAP_CYC_RAW     = (T_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int          GAP_CYC         = GAP_CYC_RAW < 1 ? 1 : GAP_CYC_RAW;
    localparam logic [15:0] RESET_CMD       = 16'h00F0;
    typedef enum {
        ST_IDLE, ST_READ, ST_CHECK, ST_RECHECK, ST_RESET, ST_FINAL
    } poll_state_t;
endpackage

/* design/flash_bus_if.sv */
// internal read/write cycle request and answer between modules
`timescale 1ns/1ps
interface flash_bus_if;
    import flash_status_pkg::*;
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              done;
    logic [DATA_W-1:0] rdata;
    modport master (output req, wr, addr, wdata, input done, rdata);
    modport slave  (input req, wr, addr, wdata, output done, rdata);
endinterface

/* design/flash_cycle_engine.sv */
// asynchronous flash read/write cycle generator
`timescale 1ns/1ps
module flash_cycle_engine
    import flash_status_pkg::*;
(
    input  wire logic                sys_clk_in,
    input  wire logic                sys_rst_in,
    flash_bus_if.slave               bus,
    input  wire logic [DATA_W-1:0]   dq_sync_in,
    output logic      [ADDR_W-1:0]   addr_out,
    output logic      [DATA_W-1:0]   dq_o_out,
    output logic                     dq_oe_out,
    output logic                     ce_n_out,
    output logic                     oe_n_out,
    output logic                     we_n_out
);
    localparam int CNT_W = 8;
    logic [CNT_W-1:0] cnt;
    logic             active;
    logic             wr_cyc;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            active    <= 1'b0;
            wr_cyc    <= 1'b0;
            cnt       <= '0;
            addr_out  <= '0;
            dq_o_out  <= '0;
            dq_oe_out <= 1'b0;
            ce_n_out  <= 1'b1;
            oe_n_out  <= 1'b1;
            we_n_out  <= 1'b1;
            bus.done  <= 1'b0;
            bus.rdata <= '0;
        end else begin
            bus.done <= 1'b0;
            if (!active && bus.req) begin
                active    <= 1'b1;
                wr_cyc    <= bus.wr;
                cnt       <= CNT_W'(ACC_CYC + 2);
                addr_out  <= bus.addr;
                dq_o_out  <= bus.wdata;
                dq_oe_out <= bus.wr;
                ce_n_out  <= 1'b0;
                oe_n_out  <= bus.wr;
                we_n_out  <= !bus.wr;
            end else if (active) begin
                cnt <= cnt - 1'b1;
                if (cnt == CNT_W'(GAP_CYC + 1)) begin
                    // one completed cycle per request
                    ce_n_out  <= 1'b1;
                    oe_n_out  <= 1'b1;
                    we_n_out  <= 1'b1;
                    bus.rdata <= dq_sync_in;
                end
                if (cnt == CNT_W'(1)) begin
                    dq_oe_out <= 1'b0;
                    active    <= 1'b0;
                    bus.done  <= 1'b1;
                end
            end
        end
    end
endmodule

/* design/flash_sync.sv */
// two-stage synchroniser for flash pins
`timescale 1ns/1ps
module flash_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* tb/flash_dev_model.sv */
// behavioural flash device answering status reads
`timescale 1ns/1ps
module flash_dev_model (
    input  wire logic        sys_clk_in,
    input  wire logic [22:0] addr_in,
    input  wire logic [15:0] dq_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic        start_in,
    input  wire logic [4:0]  mode_in,
    input  wire logic [15:0] len_in,
    input  wire logic [15:0] pd_in,
    input  wire logic [3:0]  pa_in,
    output logic      [15:0] dq_out,
    output logic             ready_busy_n_out
);
    // mode: b0 erase, b1 protected, b2 fail, b3 suspended
    logic [15:0] mem [16];
    logic        busy   = 1'b0;
    logic        failed = 1'b0;
    logic        we_q   = 1'b1;
    logic        ce_q   = 1'b1;
    logic [4:0]  md     = 5'h00;
    logic [7:0]  rd_cnt = 8'h00;
    logic [15:0] cnt;
    logic [15:0] pd;
    logic [3:0]  pa;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    end
    always @(posedge sys_clk_in) begin
        we_q <= we_n_in;
        ce_q <= ce_n_in;
        if (start_in) begin
            busy <= 1'b1;
            failed <= 1'b0;
            md <= mode_in;
            cnt <= len_in;
            pd <= pd_in;
            pa <= pa_in;
        end else if (busy && !md[3]) begin
            if (cnt != 16'h0000) cnt <= cnt - 16'h0001;
            else if (md[2]) failed <= 1'b1;
            else begin
                busy <= 1'b0;
                if (!md[1] && md[0]) for (int i = 0; i < 16; i++) mem[i] <= 16'hFFFF;
                else if (!md[1]) mem[pa] <= pd;
            end
        end
        if (we_n_in && !we_q && !ce_q && dq_in[7:0] == 8'hF0) begin
            busy <= 1'b0;
            failed <= 1'b0;
        end
    end
    always @(posedge oe_n_in) rd_cnt <= rd_cnt + 8'h01;
    always_comb begin
        dq_out = 16'h0000;
        if (ce_n_in || oe_n_in) dq_out = 16'hA5A5 ^ {16{rd_cnt[0]}};
        else if (!busy) dq_out = mem[addr_in[3:0]];
        else begin
            dq_out[7] = md[0] ? md[3] : ~pd[7];
            dq_out[6] = md[3] ? 1'b0 : rd_cnt[0];
            dq_out[5] = failed;
            dq_out[2] = md[0] && addr_in[3:2] == pa[3:2] && rd_cnt[0];
        end
    end
    assign ready_busy_n_out = !(busy && !md[3]);
endmodule

/* tb/tb.sv */
// self-checking bench for the flash status poller
`timescale 1ns/1ps
module tb;
    import flash_status_pkg::*;
    logic              sys_clk_in = 1'b0;
    logic              sys_rst_in = 1'b1;
    logic [3:0]        reg_addr   = 4'h0;
    logic [31:0]       reg_wdata  = 32'h0;
    logic              reg_wr     = 1'b0;
    logic              reg_rd     = 1'b0;
    logic              rd_seen    = 1'b0;
    logic [31:0]       reg_rdata;
    logic [31:0]       rdv;
    logic [22:0]       f_addr;
    logic [15:0]       f_dq_o;
    logic [15:0]       m_dq;
    logic              f_oe;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              rb_n;
    logic              busy;
    logic              m_start    = 1'b0;
    logic [4:0]        m_mode     = 5'h00;
    logic [15:0]       m_len      = 16'h0000;
    logic [15:0]       m_pd       = 16'h0000;
    logic [3:0]        m_pa       = 4'h0;
    logic [63:0]       expq [$];
    logic [63:0]       note;
    logic [31:0]       r;
    int                seed       = 93315;
    int                n_fail     = 0;
    int                total_checks = 0;
    int                cyc        = 0;
    wire  [15:0]       dq_bus     = f_oe ? f_dq_o : m_dq;

    flash_status_poller flash_status_poller_i (.sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .flash_addr_out(f_addr),
        .flash_dq_in(dq_bus), .flash_dq_out(f_dq_o),
        .flash_dq_oe_out(f_oe), .flash_ce_n_out(ce_n),
        .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
        .ready_busy_n_in(rb_n), .busy_out(busy));
    flash_dev_model flash_dev_model_i (.sys_clk_in(sys_clk_in),
        .addr_in(f_addr), .dq_in(dq_bus), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .start_in(m_start), .mode_in(m_mode),
        .len_in(m_len), .pd_in(m_pd), .pa_in(m_pa), .dq_out(m_dq),
        .ready_busy_n_out(rb_n));

    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e,
                           input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        @(posedge sys_clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        expq.push_back({m, e});
        @(posedge sys_clk_in);
        reg_rd <= 1'b0;
        @(negedge sys_clk_in);
        rdv = reg_rdata;
    endtask

    // one operation: device started, poller started, polled to done
    task automatic op(input logic [4:0] md, input logic tg,
                      input logic [15:0] len, input logic [3:0] a,
                      input logic [15:0] d, input logic [31:0] st,
                      input logic [31:0] sm, input logic [15:0] res);
        wr(REG_ADDR, {28'h0, a});
        wr(REG_DATA, {16'h0, d});
        @(posedge sys_clk_in);
        m_start <= 1'b1;
        m_mode <= md;
        m_len <= len;
        m_pd <= d;
        m_pa <= a;
        @(posedge sys_clk_in);
        m_start <= 1'b0;
        wr(REG_CTRL, {29'h0, tg, md[0], 1'b1});
        repeat (10) @(posedge sys_clk_in);
        chk_bit("busy", !md[3], busy);
        rdv = 32'h0;
        for (int i = 0; i < 6000 && rdv[STAT_DONE] !== 1'b1; i++)
            rd(REG_STATUS, 32'h0, 32'h0);
        rd(REG_STATUS, st, sm);
        if (!md[2]) rd(REG_RESULT, {16'h0, res},
                       md[3] ? 32'hFFFB : 32'hFFFF);
    endtask

    always @(posedge sys_clk_in) rd_seen <= reg_rd;

    always @(negedge sys_clk_in) begin
        if (rd_seen) begin
            note = expq.pop_front();
            if (note[63:32] != 32'h0)
                chk_reg("register", note[31:0], reg_rdata & note[63:32]);
        end
    end

    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        logic [15:0] d1;
        logic [15:0] d2;
        repeat (5) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        repeat (6) @(posedge sys_clk_in);
        rd(REG_STATUS, 32'h8, 32'h1F);
        rd(4'hF, 32'h0, 32'hFFFFFFFF);
        rd(REG_RESULT, 32'h0, 32'hFFFFFFFF);
        r = $random(seed);
        d1 = r[15:0];
        r = $random(seed);
        d2 = r[15:0];
        op(5'h00, 1'b0, 16'd60, 4'h3, d1, 32'hA, 32'h1F, d1);
        op(5'h00, 1'b1, 16'd60, 4'h5, d2, 32'hA, 32'h1F, d2);
        op(5'h02, 1'b1, 16'd25, 4'h9, d1, 32'hA, 32'h1F, 16'h0);
        op(5'h03, 1'b1, 16'd10000, 4'h5, d1, 32'hA, 32'h1F, d2);
        op(5'h01, 1'b0, 16'd200, 4'h4, d1, 32'hA, 32'h1F, 16'hFFFF);
        op(5'h01, 1'b1, 16'd200, 4'h6, d2, 32'hA, 32'h1F, 16'hFFFF);
        op(5'h04, 1'b0, 16'd40, 4'h7, d2, 32'h6, 32'h17, 16'h0);
        repeat (10) @(posedge sys_clk_in);
        chk_bit("busy", 1'b0, busy);
        op(5'h09, 1'b1, 16'd50, 4'h8, d1, 32'h1A, 32'h1F, 16'h0080);
        end_sim();
    end
endmodule
